/* File: gedc_ctrl.sv */
// Edge-mode registers, port event flags and low device control sequencing.
// Assumes a serial front end that turns host frames into word reads/writes,
// and port configuration masks from the same clock domain.
// Summary of operation
// - Each of ports 0..19 has its own 2-bit edge mode for its flag.
// - Mode 00 never sets the port's event flag.
// - Mode 01 sets the flag on a rising input edge.
// - Mode 10 sets the flag on a falling input edge.
// - Mode 11 sets the flag on either edge.
// - Modes packed eight per 16-bit register (four in the third), port n at bits 2(n mod 8)+1:2(n mod 8).
// - Sweep mode 00 starts no conversions, trigger ignored.
// - Sweep mode 01: a trigger starts exactly one sweep of ADC ports.
// - A sweep runs lowest to highest ADC port, skipping others.
// - Sweep mode 10: each trigger converts one port, advancing upward.
// - Sweep mode 11: sweep repeatedly, trigger ignored.
// - DAC mode 00: refresh DAC ports one after another.
// - DAC mode 01: newly written port updates next, sequence continues from it.
// - DAC mode 10: all DAC ports output preset value one.
// - DAC mode 11: all DAC ports output preset value two.
// - Rate select resets to 00, meaning 200 ksps.
// - Rate codes 01, 10, 11 give 250, 333, 400 ksps.
// - Events are recorded regardless of any interrupt mask.
// - Flags clear after interrupt read, then both status reads.
`timescale 1ns/1ns
`default_nettype none
module gedc_ctrl #(
  parameter int unsigned DAC_SLOT = 20
) (
  input  wire logic                  i_core_clk,
  input  wire logic                  i_rst,
  input  wire logic [3:0]            i_reg_addr,
  input  wire logic                  i_reg_wr,
  input  wire logic                  i_reg_rd,
  input  wire logic [15:0]           i_reg_wdata,
  output logic      [15:0]           o_reg_rdata,
  input  wire logic                  i_irq_reg_rd,
  input  wire logic [19:0]           i_port_in,
  input  wire logic [19:0]           i_port_is_input,
  input  wire logic [19:0]           i_port_is_adc,
  input  wire logic [19:0]           i_port_is_dac,
  input  wire logic                  i_convert_trigger_pin,
  input  wire logic                  i_dac_data_written,
  input  wire logic [4:0]            i_dac_written_port,
  output logic [gedc_pkg::NUM_PORTS-1:0] o_port_event_flag,
  output logic                       o_adc_start,
  output logic      [4:0]            o_adc_port,
  output logic      [1:0]            o_adc_rate_select,
  output logic                       o_dac_update,
  output logic      [4:0]            o_dac_port,
  output logic                       o_dac_use_preset,
  output logic      [11:0]           o_dac_preset_data
);
  import gedc_pkg::*;

  // Lowest flagged port above cur (or lowest at all); bit 5 = found
  function automatic logic [5:0] find_next(input logic [19:0] mask, input logic [4:0] cur,
                                           input logic from_start);
    logic [5:0] res;
    res = 6'h00;
    for (int i = 19; i >= 0; i--) begin
      if (mask[i] && (from_start || i > int'(cur))) begin
        res = {1'b1, 5'(i)};
      end
    end
    return res;
  endfunction

  // Input synchronisers and trigger edge
  logic [19:0] pin_s1_ff, pin_s2_ff, pin_prev_ff;
  logic        trg_s1_ff, trg_s2_ff, trg_prev_ff;
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      pin_s1_ff   <= '0;
      pin_s2_ff   <= '0;
      pin_prev_ff <= '0;
      trg_s1_ff   <= 1'b0;
      trg_s2_ff   <= 1'b0;
      trg_prev_ff <= 1'b0;
    end else begin
      pin_s1_ff   <= i_port_in;
      pin_s2_ff   <= pin_s1_ff;
      pin_prev_ff <= pin_s2_ff;
      trg_s1_ff   <= i_convert_trigger_pin;
      trg_s2_ff   <= trg_s1_ff;
      trg_prev_ff <= trg_s2_ff;
    end
  end
  logic trg_rise;
  assign trg_rise = trg_s2_ff & ~trg_prev_ff;

  // Register file and event flags
  logic [15:0] mode_ff [3];
  logic [15:0] ctrl_ff;
  logic [11:0] pre1_ff, pre2_ff;
  logic [19:0] flag_ff;
  logic        armed_ff, lo_seen_ff, hi_seen_ff, srst_ff;
  logic [15:0] rdata_ff;
  logic [15:0] nxt_mode [3];
  logic [15:0] nxt_ctrl, nxt_rdata;
  logic [11:0] nxt_pre1, nxt_pre2;
  logic [19:0] nxt_flag, set_evt;
  logic        nxt_armed, nxt_lo_seen, nxt_hi_seen, nxt_srst;

  always_comb begin
    logic [39:0] modes;
    logic [1:0]  md;
    logic        rise, fall;
    md    = EDGE_NONE;
    rise  = 1'b0;
    fall  = 1'b0;
    modes = {mode_ff[2][7:0], mode_ff[1], mode_ff[0]};
    for (int p = 0; p < NUM_PORTS; p++) begin
      md   = modes[2*p +: 2];
      rise = pin_s2_ff[p] & ~pin_prev_ff[p];
      fall = ~pin_s2_ff[p] & pin_prev_ff[p];
      unique case (md)
        EDGE_NONE: set_evt[p] = 1'b0;
        EDGE_RISE: set_evt[p] = rise;
        EDGE_FALL: set_evt[p] = fall;
        EDGE_BOTH: set_evt[p] = rise | fall;
      endcase
      set_evt[p] = set_evt[p] & i_port_is_input[p];
    end
    nxt_mode    = mode_ff;
    nxt_ctrl    = ctrl_ff;
    nxt_pre1    = pre1_ff;
    nxt_pre2    = pre2_ff;
    nxt_srst    = 1'b0;
    nxt_armed   = armed_ff | i_irq_reg_rd;
    nxt_lo_seen = lo_seen_ff;
    nxt_hi_seen = hi_seen_ff;
    nxt_rdata   = rdata_ff;
    nxt_flag    = flag_ff;
    if (i_reg_rd) begin
      unique case (i_reg_addr)
        OFS_EDGE_MODE_0: nxt_rdata = mode_ff[0];
        OFS_EDGE_MODE_1: nxt_rdata = mode_ff[1];
        OFS_EDGE_MODE_2: nxt_rdata = {8'h00, mode_ff[2][7:0]};
        OFS_DEV_CTRL:    nxt_rdata = ctrl_ff;
        OFS_EVENT_LO:    nxt_rdata = flag_ff[15:0];
        OFS_EVENT_HI:    nxt_rdata = {12'h000, flag_ff[19:16]};
        OFS_PRESET_ONE:  nxt_rdata = {4'h0, pre1_ff};
        OFS_PRESET_TWO:  nxt_rdata = {4'h0, pre2_ff};
        default:         nxt_rdata = 16'h0000;
      endcase
      if (armed_ff && i_reg_addr == OFS_EVENT_LO) nxt_lo_seen = 1'b1;
      if (armed_ff && i_reg_addr == OFS_EVENT_HI) nxt_hi_seen = 1'b1;
    end
    // Clear only once both halves were read after the interrupt read
    if (nxt_lo_seen && nxt_hi_seen) begin
      nxt_flag    = '0;
      nxt_armed   = i_irq_reg_rd;
      nxt_lo_seen = 1'b0;
      nxt_hi_seen = 1'b0;
    end
    nxt_flag = nxt_flag | set_evt;
    if (i_reg_wr) begin
      unique case (i_reg_addr)
        OFS_EDGE_MODE_0: nxt_mode[0] = i_reg_wdata;
        OFS_EDGE_MODE_1: nxt_mode[1] = i_reg_wdata;
        OFS_EDGE_MODE_2: nxt_mode[2] = {8'h00, i_reg_wdata[7:0]};
        OFS_DEV_CTRL: begin
          nxt_ctrl = {1'b0, i_reg_wdata[14:0]};
          nxt_srst = i_reg_wdata[SOFT_RST_BIT];
        end
        OFS_PRESET_ONE:  nxt_pre1 = i_reg_wdata[11:0];
        OFS_PRESET_TWO:  nxt_pre2 = i_reg_wdata[11:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      mode_ff    <= '{EDGE_MODE_RST, EDGE_MODE_RST, EDGE_MODE_RST};
      ctrl_ff    <= DEV_CTRL_RST;
      pre1_ff    <= PRESET_RST;
      pre2_ff    <= PRESET_RST;
      flag_ff    <= '0;
      armed_ff   <= 1'b0;
      lo_seen_ff <= 1'b0;
      hi_seen_ff <= 1'b0;
      srst_ff    <= 1'b0;
      rdata_ff   <= 16'h0000;
    end else if (srst_ff) begin
      // Soft reset acts like power-on on everything held here
      mode_ff    <= '{EDGE_MODE_RST, EDGE_MODE_RST, EDGE_MODE_RST};
      ctrl_ff    <= DEV_CTRL_RST;
      pre1_ff    <= PRESET_RST;
      pre2_ff    <= PRESET_RST;
      flag_ff    <= '0;
      armed_ff   <= 1'b0;
      lo_seen_ff <= 1'b0;
      hi_seen_ff <= 1'b0;
      srst_ff    <= 1'b0;
      rdata_ff   <= 16'h0000;
    end else begin
      mode_ff    <= nxt_mode;
      ctrl_ff    <= nxt_ctrl;
      pre1_ff    <= nxt_pre1;
      pre2_ff    <= nxt_pre2;
      flag_ff    <= nxt_flag;
      armed_ff   <= nxt_armed;
      lo_seen_ff <= nxt_lo_seen;
      hi_seen_ff <= nxt_hi_seen;
      srst_ff    <= nxt_srst;
      rdata_ff   <= nxt_rdata;
    end
  end

  logic [1:0] sweep_mode, dac_mode, rate_sel;
  assign sweep_mode = ctrl_ff[ADC_SWEEP_LSB +: 2];
  assign dac_mode   = ctrl_ff[DAC_UPDATE_LSB +: 2];
  assign rate_sel   = ctrl_ff[ADC_RATE_LSB +: 2];

  // ADC conversion pacing and sweep sequencing
  gedc_adc_e   adc_st_ff, nxt_adc_st;
  logic [7:0]  rcnt_ff, nxt_rcnt;
  logic [4:0]  aport_ff, nxt_aport, optr_ff, nxt_optr;
  logic        optr_ok_ff, nxt_optr_ok, opend_ff, nxt_opend, astart_ff, nxt_astart;
  logic        atick;
  assign atick = (rcnt_ff == 8'h00);

  always_comb begin
    logic [5:0] f;
    f           = 6'h00;
    nxt_adc_st  = adc_st_ff;
    nxt_aport   = aport_ff;
    nxt_optr    = optr_ff;
    nxt_optr_ok = optr_ok_ff;
    nxt_opend   = opend_ff;
    nxt_astart  = 1'b0;
    unique case (rate_sel)
      2'h0: nxt_rcnt = atick ? RATE0_CYC - 8'h01 : rcnt_ff - 8'h01;
      2'h1: nxt_rcnt = atick ? RATE1_CYC - 8'h01 : rcnt_ff - 8'h01;
      2'h2: nxt_rcnt = atick ? RATE2_CYC - 8'h01 : rcnt_ff - 8'h01;
      2'h3: nxt_rcnt = atick ? RATE3_CYC - 8'h01 : rcnt_ff - 8'h01;
    endcase
    unique case (sweep_mode)
      SWP_IDLE: begin
        nxt_adc_st = ADC_STOP;
        nxt_opend  = 1'b0;
      end
      SWP_SINGLE, SWP_CONT: begin
        nxt_opend = 1'b0;
        unique case (adc_st_ff)
          ADC_STOP: begin
            f = find_next(i_port_is_adc, 5'h00, 1'b1);
            // Continuous mode needs no trigger
            if (f[5] && (trg_rise || sweep_mode == SWP_CONT)) begin
              nxt_adc_st = ADC_RUN;
              nxt_aport  = f[4:0];
            end
          end
          ADC_RUN: begin
            if (atick) begin
              nxt_astart = 1'b1;
              f = find_next(i_port_is_adc, aport_ff, 1'b0);
              if (f[5]) begin
                nxt_aport = f[4:0];
              end else if (sweep_mode == SWP_CONT) begin
                f = find_next(i_port_is_adc, 5'h00, 1'b1);
                nxt_aport  = f[4:0];
                nxt_adc_st = f[5] ? ADC_RUN : ADC_STOP;
              end else begin
                nxt_adc_st = ADC_STOP;
              end
            end
          end
        endcase
      end
      SWP_ONE: begin
        nxt_adc_st = ADC_STOP;
        if (trg_rise) nxt_opend = 1'b1;
        if (opend_ff && atick) begin
          f = find_next(i_port_is_adc, optr_ff, ~optr_ok_ff);
          if (!f[5]) f = find_next(i_port_is_adc, 5'h00, 1'b1);
          if (f[5]) begin
            nxt_astart  = 1'b1;
            nxt_aport   = f[4:0];
            nxt_optr    = f[4:0];
            nxt_optr_ok = 1'b1;
          end
          nxt_opend = trg_rise;
        end
      end
    endcase
  end

  // Port whose conversion is started, captured with the start pulse
  logic [4:0] aout_ff, nxt_aout;
  assign nxt_aout = (sweep_mode == SWP_ONE) ? nxt_aport : aport_ff;

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      adc_st_ff  <= ADC_STOP;
      rcnt_ff    <= 8'h00;
      aport_ff   <= 5'h00;
      optr_ff    <= 5'h00;
      optr_ok_ff <= 1'b0;
      opend_ff   <= 1'b0;
      astart_ff  <= 1'b0;
      aout_ff    <= 5'h00;
    end else begin
      adc_st_ff  <= nxt_adc_st;
      rcnt_ff    <= nxt_rcnt;
      aport_ff   <= nxt_aport;
      optr_ff    <= nxt_optr;
      optr_ok_ff <= nxt_optr_ok;
      opend_ff   <= nxt_opend;
      astart_ff  <= nxt_astart;
      aout_ff    <= nxt_astart ? nxt_aout : aout_ff;
    end
  end

  // DAC refresh sequencing
  logic [7:0]  dcnt_ff, nxt_dcnt;
  logic [4:0]  dptr_ff, nxt_dptr, dpend_port_ff, nxt_dpend_port;
  logic        dptr_ok_ff, nxt_dptr_ok, dpend_ff, nxt_dpend, dupd_ff, nxt_dupd;
  logic        dpre_ff, nxt_dpre;
  logic [11:0] dval_ff, nxt_dval;
  logic        dtick;
  assign dtick = (dcnt_ff == 8'h00);

  always_comb begin
    logic [5:0] f;
    f              = 6'h00;
    nxt_dcnt       = dtick ? 8'(DAC_SLOT - 1) : dcnt_ff - 8'h01;
    nxt_dptr       = dptr_ff;
    nxt_dptr_ok    = dptr_ok_ff;
    nxt_dpend      = dpend_ff;
    nxt_dpend_port = dpend_port_ff;
    nxt_dupd       = 1'b0;
    nxt_dpre       = (dac_mode == DAC_PRE1) || (dac_mode == DAC_PRE2);
    nxt_dval       = (dac_mode == DAC_PRE2) ? pre2_ff : pre1_ff;
    if (dtick) begin
      if (dac_mode == DAC_IMMED && dpend_ff && i_port_is_dac[dpend_port_ff]) begin
        f = {1'b1, dpend_port_ff};
      end else begin
        f = find_next(i_port_is_dac, dptr_ff, ~dptr_ok_ff);
        if (!f[5]) f = find_next(i_port_is_dac, 5'h00, 1'b1);
      end
      if (f[5]) begin
        nxt_dupd    = 1'b1;
        nxt_dptr    = f[4:0];
        nxt_dptr_ok = 1'b1;
      end
      nxt_dpend = 1'b0;
    end
    // A request arriving before the last one was served replaces it
    if (dac_mode == DAC_IMMED && i_dac_data_written && i_port_is_dac[i_dac_written_port]) begin
      nxt_dpend      = 1'b1;
      nxt_dpend_port = i_dac_written_port;
    end
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      dcnt_ff       <= 8'h00;
      dptr_ff       <= 5'h00;
      dptr_ok_ff    <= 1'b0;
      dpend_ff      <= 1'b0;
      dpend_port_ff <= 5'h00;
      dupd_ff       <= 1'b0;
      dpre_ff       <= 1'b0;
      dval_ff       <= PRESET_RST;
    end else begin
      dcnt_ff       <= nxt_dcnt;
      dptr_ff       <= nxt_dptr;
      dptr_ok_ff    <= nxt_dptr_ok;
      dpend_ff      <= nxt_dpend;
      dpend_port_ff <= nxt_dpend_port;
      dupd_ff       <= nxt_dupd;
      dpre_ff       <= nxt_dpre;
      dval_ff       <= nxt_dval;
    end
  end

  assign o_reg_rdata       = rdata_ff;
  assign o_port_event_flag = flag_ff;
  assign o_adc_start       = astart_ff;
  assign o_adc_port        = aout_ff;
  assign o_adc_rate_select = ctrl_ff[ADC_RATE_LSB +: 2];
  assign o_dac_update      = dupd_ff;
  assign o_dac_port        = dptr_ff;
  assign o_dac_use_preset  = dpre_ff;
  assign o_dac_preset_data = dval_ff;
endmodule // gedc_ctrl
`default_nettype wire

/* File: gedc_pkg.sv */
// Constants shared by the edge-mode and device-control register block.
// Assumes a 20 MHz core clock and a 20-port mixed-signal I/O device.
package gedc_pkg;
  localparam int unsigned NUM_PORTS      = 20;
  localparam int unsigned CLK_HZ         = 20_000_000;

  // Register word offsets on the internal register port
  localparam logic [3:0] OFS_EDGE_MODE_0   = 4'h0;
  localparam logic [3:0] OFS_EDGE_MODE_1   = 4'h1;
  localparam logic [3:0] OFS_EDGE_MODE_2   = 4'h2;
  localparam logic [3:0] OFS_DEV_CTRL      = 4'h3;
  localparam logic [3:0] OFS_EVENT_LO      = 4'h4;
  localparam logic [3:0] OFS_EVENT_HI      = 4'h5;
  localparam logic [3:0] OFS_PRESET_ONE    = 4'h6;
  localparam logic [3:0] OFS_PRESET_TWO    = 4'h7;

  // Device control field positions
  localparam int unsigned ADC_SWEEP_LSB  = 0;
  localparam int unsigned DAC_UPDATE_LSB = 2;
  localparam int unsigned ADC_RATE_LSB   = 4;
  localparam int unsigned SOFT_RST_BIT   = 15;

  // Reset values
  localparam logic [15:0] EDGE_MODE_RST  = 16'h0000;
  localparam logic [15:0] DEV_CTRL_RST   = 16'h0000;
  localparam logic [11:0] PRESET_RST     = 12'h000;

  // Mode encodings
  localparam logic [1:0] EDGE_NONE = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;
  localparam logic [1:0] EDGE_BOTH = 2'h3;
  localparam logic [1:0] SWP_IDLE   = 2'h0;
  localparam logic [1:0] SWP_SINGLE = 2'h1;
  localparam logic [1:0] SWP_ONE    = 2'h2;
  localparam logic [1:0] SWP_CONT   = 2'h3;
  localparam logic [1:0] DAC_SEQ    = 2'h0;
  localparam logic [1:0] DAC_IMMED  = 2'h1;
  localparam logic [1:0] DAC_PRE1   = 2'h2;
  localparam logic [1:0] DAC_PRE2   = 2'h3;

  // Conversion rates in ksps and their periods in core cycles (rounded down)
  localparam int unsigned RATE0_KSPS = 200;
  localparam int unsigned RATE1_KSPS = 250;
  localparam int unsigned RATE2_KSPS = 333;
  localparam int unsigned RATE3_KSPS = 400;
  localparam logic [7:0] RATE0_CYC = 8'(CLK_HZ / (RATE0_KSPS * 1000));
  localparam logic [7:0] RATE1_CYC = 8'(CLK_HZ / (RATE1_KSPS * 1000));
  localparam logic [7:0] RATE2_CYC = 8'(CLK_HZ / (RATE2_KSPS * 1000));
  localparam logic [7:0] RATE3_CYC = 8'(CLK_HZ / (RATE3_KSPS * 1000));

  // DAC refresh slot period, one port per slot
  localparam int unsigned DAC_SLOT_NS  = 1000;
  localparam logic [7:0]  DAC_SLOT_CYC = 8'((DAC_SLOT_NS * (CLK_HZ / 1_000_000)) / 1000);

  typedef enum logic {ADC_STOP, ADC_RUN} gedc_adc_e;
endpackage

/* File: gedc_ctrl_chk.sv */
// Port-level checks for the edge-mode and device-control block.
// Assumes the bind below attaches it to every gedc_ctrl instance.
`timescale 1ns/1ns
`default_nettype none
module gedc_ctrl_chk #(
  parameter int unsigned DAC_SLOT = 20
) (
  input wire logic                          i_core_clk,
  input wire logic                          i_rst,
  input wire logic [3:0]                    i_reg_addr,
  input wire logic                          i_reg_wr,
  input wire logic                          i_reg_rd,
  input wire logic [15:0]                   i_reg_wdata,
  input wire logic [15:0]                   o_reg_rdata,
  input wire logic                          i_irq_reg_rd,
  input wire logic [19:0]                   i_port_in,
  input wire logic [19:0]                   i_port_is_adc,
  input wire logic [19:0]                   i_port_is_dac,
  input wire logic [gedc_pkg::NUM_PORTS-1:0] o_port_event_flag,
  input wire logic                          o_adc_start,
  input wire logic [4:0]                    o_adc_port,
  input wire logic [1:0]                    o_adc_rate_select,
  input wire logic                          o_dac_update,
  input wire logic [4:0]                    o_dac_port,
  input wire logic                          o_dac_use_preset
);
  import gedc_pkg::*;
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (i_rst);
  logic ctl_wr;
  assign ctl_wr = i_reg_wr && i_reg_addr == OFS_DEV_CTRL && !i_reg_wdata[15];

  rate_sel_a: assert property (ctl_wr |=> o_adc_rate_select == $past(i_reg_wdata[5:4]))
    else $error("rate select differs from control write");
  mode_hi_zero_a: assert property (i_reg_rd && i_reg_addr == OFS_EDGE_MODE_2 |=> o_reg_rdata[15:8] == 8'h00)
    else $error("upper byte of third edge-mode word not zero");
  flag_cause_a: assert property ((o_port_event_flag & ~$past(o_port_event_flag)
    & ~(($past(i_port_in, 3) ^ $past(i_port_in, 4)) | ($past(i_port_in, 4) ^ $past(i_port_in, 5)))) == 20'h0)
    else $error("event flag set without an input edge");
  flag_keep_a: assert property (!i_reg_rd && !$past(i_reg_wr && i_reg_addr == OFS_DEV_CTRL && i_reg_wdata[15]) |=>
    (o_port_event_flag & $past(o_port_event_flag)) == $past(o_port_event_flag))
    else $error("event flag dropped without a read");
  flag_clear_a: assert property (i_irq_reg_rd ##2 (i_reg_rd && i_reg_addr == OFS_EVENT_LO)
    ##2 (i_reg_rd && i_reg_addr == OFS_EVENT_HI) |=> o_port_event_flag == 20'h0)
    else $error("flags not cleared after status read sequence");
  adc_port_a: assert property (o_adc_start |-> i_port_is_adc[o_adc_port])
    else $error("conversion started on a port not set for ADC");
  dac_port_a: assert property (o_dac_update |-> i_port_is_dac[o_dac_port])
    else $error("refresh on a port not set for DAC");
  adc_space_a: assert property (o_adc_start |=> !o_adc_start [*8])
    else $error("conversion starts closer than the rate allows");
  preset_sel_a: assert property (ctl_wr && i_reg_wdata[3] |-> ##[1:2] o_dac_use_preset)
    else $error("preset broadcast not selected");
endmodule // gedc_ctrl_chk

bind gedc_ctrl gedc_ctrl_chk #(.DAC_SLOT(DAC_SLOT)) i_chk (
  .i_core_clk(i_core_clk), .i_rst(i_rst), .i_reg_addr(i_reg_addr), .i_reg_wr(i_reg_wr),
  .i_reg_rd(i_reg_rd), .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata),
  .i_irq_reg_rd(i_irq_reg_rd), .i_port_in(i_port_in), .i_port_is_adc(i_port_is_adc),
  .i_port_is_dac(i_port_is_dac), .o_port_event_flag(o_port_event_flag), .o_adc_start(o_adc_start),
  .o_adc_port(o_adc_port), .o_adc_rate_select(o_adc_rate_select), .o_dac_update(o_dac_update),
  .o_dac_port(o_dac_port), .o_dac_use_preset(o_dac_use_preset)
);
`default_nettype wire

/* File: gedc_host.sv */
// Host model: word register reads/writes and DAC data notices.
// Assumes the serial link is already reduced to word strobes.
`timescale 1ns/1ns
`default_nettype none
module gedc_host (
  input  wire logic        i_core_clk,
  output logic [3:0]       o_addr,
  output logic             o_wr,
  output logic             o_rd,
  output logic [15:0]      o_wdata,
  input  wire logic [15:0] i_rdata,
  output logic             o_irq_rd,
  output logic             o_dac_wr,
  output logic [4:0]       o_dac_port
);
  initial {o_addr, o_wr, o_rd, o_wdata, o_irq_rd, o_dac_wr, o_dac_port} = '0;
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    o_addr <= a;
    o_wdata <= d;
    o_wr <= 1'b1;
    @(posedge i_core_clk);
    o_wr <= 1'b0;
    @(posedge i_core_clk);
  endtask
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    o_addr <= a;
    o_rd <= 1'b1;
    @(posedge i_core_clk);
    o_rd <= 1'b0;
    @(posedge i_core_clk);
    d = i_rdata;
  endtask
  task automatic irq_rd();
    o_irq_rd <= 1'b1;
    @(posedge i_core_clk);
    o_irq_rd <= 1'b0;
    @(posedge i_core_clk);
  endtask
  // 80 us at 20 MHz before any further immediate request
  task automatic dac_wr(input logic [4:0] p);
    o_dac_port <= p;
    o_dac_wr <= 1'b1;
    @(posedge i_core_clk);
    o_dac_wr <= 1'b0;
    repeat (1600) @(posedge i_core_clk);
  endtask
endmodule // gedc_host
`default_nettype wire

/* File: tb_top.sv */
// Self-checking bench for the edge-mode and device-control block.
// Assumes gedc_host drives the register port and DAC data notices.
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import gedc_pkg::*;
  logic clk = 1'b0, rst = 1'b1, trig = 1'b0;
  logic [19:0] port_in = '0, is_in = '0, is_adc = '0, is_dac = '0, flag, ef, nv;
  wire logic [3:0] addr;
  wire logic wr, rd, irq_rd, dac_wr;
  wire logic [15:0] wdata;
  wire logic [4:0] dac_wport;
  logic [15:0] rdata, rv, w[3];
  logic adc_start, dac_upd, use_pre;
  logic [4:0] adc_port, dac_port, aq[$], dq[$];
  logic [1:0] rate;
  logic [11:0] pre_data, pv[2];
  int m[20];
  int n_errors = 0, n_tests = 0, cyc = 0, n, p, j;

  gedc_ctrl #(.DAC_SLOT(4)) i_dut (
    .i_core_clk(clk), .i_rst(rst), .i_reg_addr(addr), .i_reg_wr(wr), .i_reg_rd(rd),
    .i_reg_wdata(wdata), .o_reg_rdata(rdata), .i_irq_reg_rd(irq_rd), .i_port_in(port_in),
    .i_port_is_input(is_in), .i_port_is_adc(is_adc), .i_port_is_dac(is_dac),
    .i_convert_trigger_pin(trig), .i_dac_data_written(dac_wr), .i_dac_written_port(dac_wport),
    .o_port_event_flag(flag), .o_adc_start(adc_start), .o_adc_port(adc_port),
    .o_adc_rate_select(rate), .o_dac_update(dac_upd), .o_dac_port(dac_port),
    .o_dac_use_preset(use_pre), .o_dac_preset_data(pre_data)
  );
  gedc_host i_host (
    .i_core_clk(clk), .o_addr(addr), .o_wr(wr), .o_rd(rd), .o_wdata(wdata), .i_rdata(rdata),
    .o_irq_rd(irq_rd), .o_dac_wr(dac_wr), .o_dac_port(dac_wport)
  );

  always #25 clk = ~clk;
  // Outputs are taken mid-cycle, away from the edge that moves them
  always @(negedge clk) begin
    if (adc_start === 1'b1)
      aq.push_back(adc_port);
    if (dac_upd === 1'b1)
      dq.push_back(dac_port);
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 40000) begin
      n_errors++;
      summarize();
    end
  end

  task automatic chk(string s, logic [31:0] e, logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", s, e, g);
    end
  endtask
  function automatic int nxt(logic [19:0] msk, int q);
    for (int i = 1; i <= 20; i++)
      if (msk[(q + i) % 20])
        return (q + i) % 20;
    return -1;
  endfunction
  task automatic seq_chk(string s, ref logic [4:0] q[$], input logic [19:0] msk);
    for (int i = 1; i < q.size(); i++)
      chk(s, 32'(nxt(msk, int'(q[i - 1]))), 32'(q[i]));
  endtask
  task automatic trig_pulse();
    trig <= 1'b1;
    repeat (4) @(posedge clk);
    trig <= 1'b0;
    repeat (4) @(posedge clk);
  endtask
  task automatic summarize();
    if (n_errors == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  initial begin
    void'($urandom(32'hC4A5));
    @(posedge clk);
    is_adc <= 20'($urandom & $urandom) | 20'h00011;
    is_dac <= 20'($urandom) | 20'h00024;
    @(posedge clk);
    rst <= 1'b0;
    n = $countones(is_adc);
    chk("rate at reset", 32'h0, 32'(rate));
    for (int a = 0; a < 5; a++) begin
      i_host.rd(a == 4 ? 4'hF : 4'(a), rv);
      chk("reset read", 32'h0, 32'(rv));
    end
    repeat (2) begin
      is_in <= 20'hFFFFF ^ (20'h1 << ($urandom % 20));
      p = $urandom % 4;
      for (int q = 0; q < 20; q++) begin
        m[q] = (q + p) % 4;
        w[q / 8][2 * (q % 8) +: 2] = 2'(m[q]);
      end
      w[2][15:8] = 8'($urandom);
      for (int i = 0; i < 3; i++) begin
        i_host.wr(4'(i), w[i]);
        i_host.rd(4'(i), rv);
        chk("edge mode word", 32'(i == 2 ? w[i] & 16'h00FF : w[i]), 32'(rv));
      end
      ef = '0;
      repeat (3) begin
        nv = 20'($urandom);
        for (int q = 0; q < 20; q++)
          if (is_in[q] && ((m[q] == 1 && nv[q] && !port_in[q]) || (m[q] == 2 && !nv[q] && port_in[q])
              || (m[q] == 3 && nv[q] != port_in[q])))
            ef[q] = 1'b1;
        port_in <= nv;
        repeat (8) @(posedge clk);
        chk("event flags", 32'(ef), 32'(flag));
      end
      i_host.rd(OFS_EVENT_LO, rv);
      chk("status low", 32'(ef[15:0]), 32'(rv));
      i_host.rd(OFS_EVENT_HI, rv);
      chk("status high", 32'(ef[19:16]), 32'(rv));
      chk("flags kept", 32'(ef), 32'(flag));
      i_host.irq_rd();
      i_host.rd(OFS_EVENT_LO, rv);
      i_host.rd(OFS_EVENT_HI, rv);
      chk("flags cleared", 32'h0, 32'(flag));
    end
    for (int r = 0; r < 4; r++) begin
      i_host.wr(OFS_DEV_CTRL, 16'(r << 4));
      chk("rate select", 32'(r), 32'(rate));
    end
    aq.delete();
    trig_pulse();
    repeat (300) @(posedge clk);
    chk("idle starts", 32'h0, 32'(aq.size()));
    i_host.wr(OFS_DEV_CTRL, 16'h0031);
    trig_pulse();
    repeat (50 * n + 200) @(posedge clk);
    p = 19;
    for (int i = 0; i < n; i++) begin
      p = nxt(is_adc, p);
      chk("sweep port", 32'(p), 32'(aq[i]));
    end
    chk("sweep count", 32'(n), 32'(aq.size()));
    i_host.wr(OFS_DEV_CTRL, 16'h0032);
    aq.delete();
    p = 19;
    for (int i = 0; i <= n; i++) begin
      trig_pulse();
      repeat (120) @(posedge clk);
      p = nxt(is_adc, p);
      chk("single port", 32'(p), 32'(aq[i]));
    end
    chk("single count", 32'(n + 1), 32'(aq.size()));
    i_host.wr(OFS_DEV_CTRL, 16'h0033);
    aq.delete();
    trig_pulse();
    repeat (100 * n + 100) @(posedge clk);
    i_host.wr(OFS_DEV_CTRL, 16'h0030);
    chk("continuous count", 32'h1, 32'(aq.size() >= 2 * n));
    seq_chk("continuous port", aq, is_adc);
    dq.delete();
    repeat (200) @(posedge clk);
    chk("refresh count", 32'h1, 32'(dq.size() > 8));
    seq_chk("refresh port", dq, is_dac);
    i_host.wr(OFS_DEV_CTRL, 16'h0034);
    chk("preset off", 32'h0, 32'(use_pre));
    foreach (pv[k]) begin
      p = k == 0 ? 5 : 2;
      dq.delete();
      i_host.dac_wr(5'(p));
      // A plain refresh of any port may come just before the served one
      j = dq[1] === 5'(p) ? 1 : 0;
      chk("immediate port", 32'(p), 32'(dq[j]));
      chk("after immediate", 32'(nxt(is_dac, p)), 32'(dq[j + 1]));
    end
    foreach (pv[k]) begin
      rv = 16'($urandom);
      pv[k] = rv[11:0];
      i_host.wr(k == 0 ? OFS_PRESET_ONE : OFS_PRESET_TWO, rv);
      i_host.rd(k == 0 ? OFS_PRESET_ONE : OFS_PRESET_TWO, rv);
      chk("preset word", 32'(pv[k]), 32'(rv));
    end
    foreach (pv[k]) begin
      i_host.wr(OFS_DEV_CTRL, k == 0 ? 16'h0038 : 16'h003C);
      @(posedge clk);
      chk("preset used", 32'h1, 32'(use_pre));
      chk("preset data", 32'(pv[k]), 32'(pre_data));
    end
    i_host.wr(OFS_DEV_CTRL, 16'h8000);
    chk("soft reset rate", 32'h0, 32'(rate));
    i_host.rd(OFS_PRESET_ONE, rv);
    chk("soft reset word", 32'h0, 32'(rv));
    chk("soft reset preset", 32'h0, 32'(use_pre));
    summarize();
  end
endmodule // tb_top
`default_nettype wire
